// >>> rtl/hsh_unit.sv
`timescale 1ns/10ps
`default_nettype none

module hsh_unit (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic xlen64_in,
	input wire logic issue_valid_in,
	input wire hsh_pkg::hsh_op_t issue_op_in,
	input wire logic [4:0] issue_rd_in,
	input wire logic [63:0] first_source_register_in,
	input wire logic [63:0] second_source_register_in,
	output logic wb_valid_out,
	output logic wb_illegal_out,
	output logic [4:0] wb_rd_out,
	output logic [63:0] wb_data_out
);

	// ----------------------------------------
	// operand forming
	// ----------------------------------------
	logic [31:0] word_w;
	logic [31:0] ssz_w;
	logic [31:0] sso_w;
	logic [31:0] bsz_w;
	logic [31:0] bso_w;
	logic [63:0] pair_w;
	logic [63:0] ssz64_w;
	logic [63:0] sso64_w;
	logic [63:0] bsz64_w;
	logic [63:0] bso64_w;
	logic [63:0] pair_sw_w;
	logic [63:0] ssz64_sw_w;
	logic [63:0] sso64_sw_w;

	// low 32 bits are the whole register on a 32-bit machine
	assign word_w = first_source_register_in[31:0];
	// second source is the more significant half of the pair
	assign pair_w = {second_source_register_in[31:0], first_source_register_in[31:0]};
	// upper ops get the high word in the first source, so their pair is the other way round
	assign pair_sw_w = {first_source_register_in[31:0], second_source_register_in[31:0]};

	hsh_word_xform u_word_xform (
		.word_in(word_w),
		.small_sigma_zero_out(ssz_w),
		.small_sigma_one_out(sso_w),
		.big_sigma_zero_out(bsz_w),
		.big_sigma_one_out(bso_w)
	);

	// ----------------------------------------
	// 512-family transforms on the pair
	// ----------------------------------------
	always_comb begin
		ssz64_w = hsh_pkg::ror64(pair_w, hsh_pkg::S512_SIG0_R1)
			^ hsh_pkg::ror64(pair_w, hsh_pkg::S512_SIG0_R2)
			^ (pair_w >> hsh_pkg::S512_SIG0_SH);
		sso64_w = hsh_pkg::ror64(pair_w, hsh_pkg::S512_SIG1_R1)
			^ hsh_pkg::ror64(pair_w, hsh_pkg::S512_SIG1_R2)
			^ (pair_w >> hsh_pkg::S512_SIG1_SH);
		bsz64_w = hsh_pkg::ror64(pair_w, hsh_pkg::S512_SUM0_R1)
			^ hsh_pkg::ror64(pair_w, hsh_pkg::S512_SUM0_R2)
			^ hsh_pkg::ror64(pair_w, hsh_pkg::S512_SUM0_R3);
		bso64_w = hsh_pkg::ror64(pair_w, hsh_pkg::S512_SUM1_R1)
			^ hsh_pkg::ror64(pair_w, hsh_pkg::S512_SUM1_R2)
			^ hsh_pkg::ror64(pair_w, hsh_pkg::S512_SUM1_R3);
		// shifts are not symmetric, so the small sigmas need the reordered pair too
		ssz64_sw_w = hsh_pkg::ror64(pair_sw_w, hsh_pkg::S512_SIG0_R1)
			^ hsh_pkg::ror64(pair_sw_w, hsh_pkg::S512_SIG0_R2)
			^ (pair_sw_w >> hsh_pkg::S512_SIG0_SH);
		sso64_sw_w = hsh_pkg::ror64(pair_sw_w, hsh_pkg::S512_SIG1_R1)
			^ hsh_pkg::ror64(pair_sw_w, hsh_pkg::S512_SIG1_R2)
			^ (pair_sw_w >> hsh_pkg::S512_SIG1_SH);
	end

	// ----------------------------------------
	// result select and writeback stage
	// ----------------------------------------
	logic wb_valid_d;
	logic wb_valid_q;
	logic wb_illegal_d;
	logic wb_illegal_q;
	logic [4:0] wb_rd_d;
	logic [4:0] wb_rd_q;
	logic [63:0] wb_data_d;
	logic [63:0] wb_data_q;
	logic [31:0] res32_w;
	logic is_split_w;

	// every operand reaches writeback after exactly one edge; no early-out paths
	always_comb begin
		res32_w = 32'h00000000;
		is_split_w = 1'b0;
		unique case (issue_op_in)
			// same word transforms for the 224 and 256 digests
			hsh_pkg::HASH256_SMALL_SIGMA_ZERO: res32_w = ssz_w;
			hsh_pkg::HASH256_SMALL_SIGMA_ONE: res32_w = sso_w;
			hsh_pkg::HASH256_BIG_SIGMA_ZERO: res32_w = bsz_w;
			hsh_pkg::HASH256_BIG_SIGMA_ONE: res32_w = bso_w;
			hsh_pkg::HASH512_SMALL_SIGMA_ZERO_LOWER: begin
				res32_w = ssz64_w[31:0];
				is_split_w = 1'b1;
			end
			hsh_pkg::HASH512_SMALL_SIGMA_ZERO_UPPER: begin
				// high word arrives in the first source for the upper op
				res32_w = ssz64_sw_w[63:32];
				is_split_w = 1'b1;
			end
			hsh_pkg::HASH512_SMALL_SIGMA_ONE_LOWER: begin
				res32_w = sso64_w[31:0];
				is_split_w = 1'b1;
			end
			hsh_pkg::HASH512_SMALL_SIGMA_ONE_UPPER: begin
				res32_w = sso64_sw_w[63:32];
				is_split_w = 1'b1;
			end
			hsh_pkg::HASH512_BIG_SIGMA_ZERO_SPLIT: begin
				// rotation is symmetric: the swapped issue yields the other half
				res32_w = bsz64_w[31:0];
				is_split_w = 1'b1;
			end
			hsh_pkg::HASH512_BIG_SIGMA_ONE_SPLIT: begin
				res32_w = bso64_w[31:0];
				is_split_w = 1'b1;
			end
			default: begin
				res32_w = 32'h00000000;
				is_split_w = 1'b1;
			end
		endcase
		wb_valid_d = issue_valid_in;
		wb_rd_d = issue_valid_in ? issue_rd_in : wb_rd_q;
		wb_illegal_d = issue_valid_in & is_split_w & xlen64_in;
		if (!issue_valid_in) begin
			wb_data_d = wb_data_q;
		end else if (wb_illegal_d) begin
			wb_data_d = hsh_pkg::WB_DATA_RST;
		end else if (xlen64_in) begin
			wb_data_d = {{32{res32_w[31]}}, res32_w};
		end else begin
			wb_data_d = {32'h00000000, res32_w};
		end
		// unknown op codes are refused on either register width
		if (issue_valid_in && is_split_w && res32_w == 32'h00000000
				&& !(issue_op_in inside {hsh_pkg::HASH512_SMALL_SIGMA_ZERO_LOWER,
				hsh_pkg::HASH512_SMALL_SIGMA_ZERO_UPPER,
				hsh_pkg::HASH512_SMALL_SIGMA_ONE_LOWER,
				hsh_pkg::HASH512_SMALL_SIGMA_ONE_UPPER,
				hsh_pkg::HASH512_BIG_SIGMA_ZERO_SPLIT,
				hsh_pkg::HASH512_BIG_SIGMA_ONE_SPLIT})) begin
			wb_illegal_d = 1'b1;
			wb_data_d = hsh_pkg::WB_DATA_RST;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			wb_valid_q <= 1'b0;
			wb_illegal_q <= 1'b0;
			wb_rd_q <= hsh_pkg::WB_RD_RST;
			wb_data_q <= hsh_pkg::WB_DATA_RST;
		end else begin
			wb_valid_q <= wb_valid_d;
			wb_illegal_q <= wb_illegal_d;
			wb_rd_q <= wb_rd_d;
			wb_data_q <= wb_data_d;
		end
	end

	assign wb_valid_out = wb_valid_q;
	assign wb_illegal_out = wb_illegal_q;
	assign wb_rd_out = wb_rd_q;
	assign wb_data_out = wb_data_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	logic [31:0] a_w;
	logic [31:0] b_w;
	logic ok32_w;
	assign a_w = first_source_register_in[31:0];
	assign b_w = second_source_register_in[31:0];
	assign ok32_w = issue_valid_in && !xlen64_in;

	sequence issued_s;
		issue_valid_in;
	endsequence

	sequence answered_s;
		wb_valid_out ##0 (wb_rd_out == $past(issue_rd_in));
	endsequence

	fixed_latency_a: assert property (issued_s |=> answered_s)
		else $error("result missing one cycle after issue");
	no_spurious_a: assert property (!issue_valid_in |=> !wb_valid_out)
		else $error("writeback without issue");
	narrow_upper_a: assert property (ok32_w |=> wb_data_out[63:32] == 32'h00000000)
		else $error("upper bits set on 32-bit machine");
	sign_extend_a: assert property (issue_valid_in && xlen64_in
			&& issue_op_in == hsh_pkg::HASH256_BIG_SIGMA_ONE
			|=> wb_data_out == {{32{wb_data_out[31]}}, wb_data_out[31:0]}
			&& !wb_illegal_out)
		else $error("256 result not sign extended");
	small_zero_a: assert property (issue_valid_in
			&& issue_op_in == hsh_pkg::HASH256_SMALL_SIGMA_ZERO
			|=> wb_data_out[31:0] == ({$past(a_w[6:0]), $past(a_w[31:7])}
			^ {$past(a_w[17:0]), $past(a_w[31:18])} ^ ($past(a_w) >> 3)))
		else $error("small sigma zero mismatch");
	split_refused_a: assert property (issue_valid_in && xlen64_in
			&& issue_op_in == hsh_pkg::HASH512_BIG_SIGMA_ZERO_SPLIT
			|=> wb_illegal_out && wb_data_out == 64'h0000000000000000)
		else $error("split op accepted on 64-bit machine");
	sig0_lower_a: assert property (ok32_w
			&& issue_op_in == hsh_pkg::HASH512_SMALL_SIGMA_ZERO_LOWER
			|=> wb_data_out[31:0] == (($past(a_w) >> 1) ^ ($past(a_w) >> 7)
			^ ($past(a_w) >> 8) ^ ($past(b_w) << 31) ^ ($past(b_w) << 25)
			^ ($past(b_w) << 24)))
		else $error("small sigma zero lower half mismatch");
	sig0_upper_a: assert property (ok32_w
			&& issue_op_in == hsh_pkg::HASH512_SMALL_SIGMA_ZERO_UPPER
			|=> wb_data_out[31:0] == (($past(a_w) >> 1) ^ ($past(a_w) >> 7)
			^ ($past(a_w) >> 8) ^ ($past(b_w) << 31) ^ ($past(b_w) << 24)))
		else $error("small sigma zero upper half mismatch");
	sig1_lower_a: assert property (ok32_w
			&& issue_op_in == hsh_pkg::HASH512_SMALL_SIGMA_ONE_LOWER
			|=> wb_data_out[31:0] == (($past(a_w) << 3) ^ ($past(a_w) >> 6)
			^ ($past(a_w) >> 19) ^ ($past(b_w) >> 29) ^ ($past(b_w) << 26)
			^ ($past(b_w) << 13)))
		else $error("small sigma one lower half mismatch");
	sig1_upper_a: assert property (ok32_w
			&& issue_op_in == hsh_pkg::HASH512_SMALL_SIGMA_ONE_UPPER
			|=> wb_data_out[31:0] == (($past(a_w) << 3) ^ ($past(a_w) >> 6)
			^ ($past(a_w) >> 19) ^ ($past(b_w) >> 29) ^ ($past(b_w) << 13)))
		else $error("small sigma one upper half mismatch");
	sum0_split_a: assert property (ok32_w
			&& issue_op_in == hsh_pkg::HASH512_BIG_SIGMA_ZERO_SPLIT
			|=> wb_data_out[31:0] == (($past(a_w) << 25) ^ ($past(a_w) << 30)
			^ ($past(a_w) >> 28) ^ ($past(b_w) >> 7) ^ ($past(b_w) >> 2)
			^ ($past(b_w) << 4)))
		else $error("big sigma zero split mismatch");
	sum1_split_a: assert property (ok32_w
			&& issue_op_in == hsh_pkg::HASH512_BIG_SIGMA_ONE_SPLIT
			|=> wb_data_out[31:0] == (($past(a_w) << 23) ^ ($past(a_w) >> 14)
			^ ($past(a_w) >> 18) ^ ($past(b_w) >> 9) ^ ($past(b_w) << 18)
			^ ($past(b_w) << 14)))
		else $error("big sigma one split mismatch");

endmodule : hsh_unit

`default_nettype wire

// >>> rtl/hsh_pkg.sv
package hsh_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int unsigned WORD_W = 32;
	localparam int unsigned REG_W = 64;
	localparam int unsigned RD_W = 5;

	// ----------------------------------------
	// 256-family rotate and shift amounts
	// ----------------------------------------
	localparam int unsigned S256_SIG0_R1 = 7;
	localparam int unsigned S256_SIG0_R2 = 18;
	localparam int unsigned S256_SIG0_SH = 3;
	localparam int unsigned S256_SIG1_R1 = 17;
	localparam int unsigned S256_SIG1_R2 = 19;
	localparam int unsigned S256_SIG1_SH = 10;
	localparam int unsigned S256_SUM0_R1 = 2;
	localparam int unsigned S256_SUM0_R2 = 13;
	localparam int unsigned S256_SUM0_R3 = 22;
	localparam int unsigned S256_SUM1_R1 = 6;
	localparam int unsigned S256_SUM1_R2 = 11;
	localparam int unsigned S256_SUM1_R3 = 25;

	// ----------------------------------------
	// 512-family rotate and shift amounts
	// ----------------------------------------
	localparam int unsigned S512_SIG0_R1 = 1;
	localparam int unsigned S512_SIG0_R2 = 8;
	localparam int unsigned S512_SIG0_SH = 7;
	localparam int unsigned S512_SIG1_R1 = 19;
	localparam int unsigned S512_SIG1_R2 = 61;
	localparam int unsigned S512_SIG1_SH = 6;
	localparam int unsigned S512_SUM0_R1 = 28;
	localparam int unsigned S512_SUM0_R2 = 34;
	localparam int unsigned S512_SUM0_R3 = 39;
	localparam int unsigned S512_SUM1_R1 = 14;
	localparam int unsigned S512_SUM1_R2 = 18;
	localparam int unsigned S512_SUM1_R3 = 41;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [REG_W-1:0] WB_DATA_RST = 64'h0000000000000000;
	localparam logic [RD_W-1:0] WB_RD_RST = 5'h00;

	// ----------------------------------------
	// operations
	// ----------------------------------------
	typedef enum logic [3:0] {
		HASH256_SMALL_SIGMA_ZERO,
		HASH256_SMALL_SIGMA_ONE,
		HASH256_BIG_SIGMA_ZERO,
		HASH256_BIG_SIGMA_ONE,
		HASH512_SMALL_SIGMA_ZERO_LOWER,
		HASH512_SMALL_SIGMA_ZERO_UPPER,
		HASH512_SMALL_SIGMA_ONE_LOWER,
		HASH512_SMALL_SIGMA_ONE_UPPER,
		HASH512_BIG_SIGMA_ZERO_SPLIT,
		HASH512_BIG_SIGMA_ONE_SPLIT
	} hsh_op_t;

	function automatic logic [WORD_W-1:0] ror32(input logic [WORD_W-1:0] x,
			input int unsigned n);
		return (x >> n) | (x << (WORD_W - n));
	endfunction : ror32

	function automatic logic [REG_W-1:0] ror64(input logic [REG_W-1:0] x,
			input int unsigned n);
		return (x >> n) | (x << (REG_W - n));
	endfunction : ror64

endpackage : hsh_pkg

// >>> rtl/hsh_word_xform.sv
`timescale 1ns/10ps
`default_nettype none

module hsh_word_xform (
	input wire logic [31:0] word_in,
	output logic [31:0] small_sigma_zero_out,
	output logic [31:0] small_sigma_one_out,
	output logic [31:0] big_sigma_zero_out,
	output logic [31:0] big_sigma_one_out
);

	// ----------------------------------------
	// 256-family word transforms
	// ----------------------------------------
	// pure xor of fixed wiring: no data-dependent path length
	always_comb begin
		small_sigma_zero_out = hsh_pkg::ror32(word_in, hsh_pkg::S256_SIG0_R1)
			^ hsh_pkg::ror32(word_in, hsh_pkg::S256_SIG0_R2)
			^ (word_in >> hsh_pkg::S256_SIG0_SH);
		small_sigma_one_out = hsh_pkg::ror32(word_in, hsh_pkg::S256_SIG1_R1)
			^ hsh_pkg::ror32(word_in, hsh_pkg::S256_SIG1_R2)
			^ (word_in >> hsh_pkg::S256_SIG1_SH);
		big_sigma_zero_out = hsh_pkg::ror32(word_in, hsh_pkg::S256_SUM0_R1)
			^ hsh_pkg::ror32(word_in, hsh_pkg::S256_SUM0_R2)
			^ hsh_pkg::ror32(word_in, hsh_pkg::S256_SUM0_R3);
		big_sigma_one_out = hsh_pkg::ror32(word_in, hsh_pkg::S256_SUM1_R1)
			^ hsh_pkg::ror32(word_in, hsh_pkg::S256_SUM1_R2)
			^ hsh_pkg::ror32(word_in, hsh_pkg::S256_SUM1_R3);
	end

endmodule : hsh_word_xform

`default_nettype wire

// >>> verif/hsh_core_model.sv
`timescale 1ns/10ps
`default_nettype none

module hsh_core_model (
	output logic issue_valid_out,
	output hsh_pkg::hsh_op_t issue_op_out,
	output logic [4:0] issue_rd_out,
	output logic [63:0] first_source_register_out,
	output logic [63:0] second_source_register_out
);
	// ----------------------------------------
	// issue side of the integer pipeline
	// ----------------------------------------
	initial begin
		issue_valid_out = 1'b0;
		issue_op_out = hsh_pkg::HASH256_SMALL_SIGMA_ZERO;
		issue_rd_out = 5'h00;
		first_source_register_out = 64'h0000000000000000;
		second_source_register_out = 64'h0000000000000000;
	end

	// called just after a rising edge; idle slots scramble the operand lines
	task automatic drive(input logic v, input hsh_pkg::hsh_op_t op, input logic [4:0] rd,
			input logic [63:0] a, input logic [63:0] b);
		issue_valid_out <= v;
		if (v) begin
			issue_op_out <= op;
			issue_rd_out <= rd;
			first_source_register_out <= a;
			second_source_register_out <= b;
		end else begin
			issue_op_out <= hsh_pkg::hsh_op_t'(~issue_op_out);
			issue_rd_out <= ~issue_rd_out;
			first_source_register_out <= ~first_source_register_out;
			second_source_register_out <= ~second_source_register_out;
		end
	endtask : drive
endmodule : hsh_core_model

`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic xlen64_in = 1'b0;
	logic issue_valid;
	hsh_pkg::hsh_op_t issue_op;
	logic [4:0] issue_rd;
	logic [63:0] src_first;
	logic [63:0] src_second;
	logic wb_valid_out;
	logic wb_illegal_out;
	logic [4:0] wb_rd_out;
	logic [63:0] wb_data_out;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	logic pend_v = 1'b0;
	logic pend_ill = 1'b0;
	logic [4:0] pend_rd = 5'h00;
	logic [63:0] pend_d = 64'h0000000000000000;

	// ----------------------------------------
	// clock, partner and block
	// ----------------------------------------
	always #50 core_clk_in = ~core_clk_in;

	hsh_core_model i_core (
		.issue_valid_out(issue_valid),
		.issue_op_out(issue_op),
		.issue_rd_out(issue_rd),
		.first_source_register_out(src_first),
		.second_source_register_out(src_second)
	);

	hsh_unit i_dut (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.xlen64_in(xlen64_in),
		.issue_valid_in(issue_valid),
		.issue_op_in(issue_op),
		.issue_rd_in(issue_rd),
		.first_source_register_in(src_first),
		.second_source_register_in(src_second),
		.wb_valid_out(wb_valid_out),
		.wb_illegal_out(wb_illegal_out),
		.wb_rd_out(wb_rd_out),
		.wb_data_out(wb_data_out)
	);

	// ----------------------------------------
	// reference transforms, kept apart from the package helpers
	// ----------------------------------------
	function automatic logic [31:0] rot32(input logic [31:0] x, input int n);
		return (x >> n) | (x << (32 - n));
	endfunction : rot32

	function automatic logic [63:0] rot64(input logic [63:0] x, input int n);
		return (x >> n) | (x << (64 - n));
	endfunction : rot64

	function automatic logic [31:0] f256(input int sel, input logic [31:0] x);
		case (sel)
			0: return rot32(x, 7) ^ rot32(x, 18) ^ (x >> 3);
			1: return rot32(x, 17) ^ rot32(x, 19) ^ (x >> 10);
			2: return rot32(x, 2) ^ rot32(x, 13) ^ rot32(x, 22);
			default: return rot32(x, 6) ^ rot32(x, 11) ^ rot32(x, 25);
		endcase
	endfunction : f256

	function automatic logic [63:0] f512(input int sel, input logic [63:0] x);
		case (sel)
			0: return rot64(x, 1) ^ rot64(x, 8) ^ (x >> 7);
			1: return rot64(x, 19) ^ rot64(x, 61) ^ (x >> 6);
			2: return rot64(x, 28) ^ rot64(x, 34) ^ rot64(x, 39);
			default: return rot64(x, 14) ^ rot64(x, 18) ^ rot64(x, 41);
		endcase
	endfunction : f512

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run

	// one issue slot; judges the answer to the slot before, which must land one edge late
	task automatic step(input logic v, input hsh_pkg::hsh_op_t op, input logic [4:0] rd,
			input logic [63:0] a, input logic [63:0] b, input logic [63:0] d, input logic ill);
		@(posedge core_clk_in);
		i_core.drive(v, op, rd, a, b);
		#1;
		check("wb_valid", {63'h0, wb_valid_out}, {63'h0, pend_v});
		check("wb_illegal", {63'h0, wb_illegal_out}, {63'h0, pend_v & pend_ill});
		check("wb_rd", {59'h0, wb_rd_out}, {59'h0, pend_rd});
		check("wb_data", wb_data_out, pend_d);
		pend_v = v;
		pend_ill = ill;
		pend_rd = v ? rd : pend_rd;
		pend_d = v ? d : pend_d;
	endtask : step

	task automatic idle();
		step(1'b0, hsh_pkg::HASH256_SMALL_SIGMA_ZERO, 5'h00, 64'h0, 64'h0, 64'h0, 1'b0);
	endtask : idle

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic run_256(input logic wide);
		logic [31:0] words [4] = '{32'h80000001, 32'hFFFFFFFF, 32'h00000000, 32'h12345678};
		logic [31:0] r;
		@(posedge core_clk_in);
		xlen64_in <= wide;
		// back to back over all four transforms and boundary words
		for (int w = 0; w < 4; w++) begin
			for (int s = 0; s < 4; s++) begin
				r = f256(s, words[w]);
				step(1'b1, hsh_pkg::hsh_op_t'(s), 5'(w * 8 + s + 28), {32'hA5A5A5A5, words[w]},
					64'h0, wide ? {{32{r[31]}}, r} : {32'h0, r}, 1'b0);
			end
		end
		idle();
	endtask : run_256

	task automatic run_split();
		logic [31:0] lo;
		logic [31:0] hi;
		logic [63:0] r;
		@(posedge core_clk_in);
		xlen64_in <= 1'b0;
		for (int p = 0; p < 2; p++) begin
			lo = p ? 32'hFFFFFFFE : 32'h89ABCDEF;
			hi = p ? 32'h80000000 : 32'h01234567;
			for (int f = 0; f < 4; f++) begin
				r = f512(f, {hi, lo});
				// low half from (lo, hi), high half from the swapped pair
				step(1'b1, hsh_pkg::hsh_op_t'(f < 2 ? 4 + 2 * f : 6 + f), 5'(f + 1),
					{32'h0, lo}, {32'h0, hi}, {32'h0, r[31:0]}, 1'b0);
				step(1'b1, hsh_pkg::hsh_op_t'(f < 2 ? 5 + 2 * f : 6 + f), 5'(f + 17),
					{32'h0, hi}, {32'h0, lo}, {32'h0, r[63:32]}, 1'b0);
			end
		end
		step(1'b1, hsh_pkg::hsh_op_t'(4'hF), 5'h0B, 64'h1, 64'h2, 64'h0, 1'b1);
		idle();
	endtask : run_split

	task automatic run_refused_wide();
		@(posedge core_clk_in);
		xlen64_in <= 1'b1;
		// split operations are absent on the wide machine
		for (int op = 4; op < 10; op++) begin
			step(1'b1, hsh_pkg::hsh_op_t'(op), 5'(op), 64'h0123456789ABCDEF,
				64'hFEDCBA9876543210, 64'h0, 1'b1);
		end
		idle();
		idle();
	endtask : run_refused_wide

	// ----------------------------------------
	// main sequence and hang guard
	// ----------------------------------------
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			complete_run();
		end
	end

	initial begin
		repeat (3) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		#1;
		check("reset valid", {63'h0, wb_valid_out}, 64'h0);
		check("reset data", wb_data_out, 64'h0);
		check("reset illegal", {63'h0, wb_illegal_out}, 64'h0);
		check("reset rd", {59'h0, wb_rd_out}, 64'h0);
		run_256(1'b0);
		run_split();
		run_256(1'b1);
		run_refused_wide();
		complete_run();
	end
endmodule : tb_top

`default_nettype wire
